// [lhrsf_core.sv]
// lhrsf_core: mode control, register reset and supply flags of the relay switch
// assumes pins and comparators are asynchronous; spi clock is slow enough to sample
`timescale 1ns/100ps
`default_nettype none
module lhrsf_core (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        standby_pin,
  input  wire logic [1:0]  parallel_ctrl_wires,
  input  wire logic        vs_below_uv,
  input  wire logic        vs_above_op,
  input  wire logic        vdd_below_uv,
  input  wire logic        vdd_in_lop,
  input  wire logic        ol_on_det,
  input  wire logic        ol_off_det,
  input  wire logic [7:0]  chan_fault,
  input  wire logic [7:0]  chan_sense,
  input  wire logic        spi_sclk,
  input  wire logic        spi_csn,
  input  wire logic        spi_mosi,
  output logic             spi_miso,
  output logic             spi_miso_oe,
  output logic [7:0]       chan_on,
  input  wire logic [3:0]  bus_addr,
  input  wire logic [31:0] bus_wdata,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  output logic [31:0]      bus_rdata,
  output logic             irq
);
  localparam int SW = $clog2(lhrsf_pkg::TRANS_CYC + 1);
  localparam logic [SW-1:0] SETTLE_LD = SW'(lhrsf_pkg::TRANS_CYC);
  localparam logic [4:0] FRAME_CNT = 5'(lhrsf_pkg::FRAME_BITS);
  // csn idles high so no false frame edge is seen after reset
  localparam logic [27:0] SYNC_RST = 28'h0000002;

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic [27:0] meta_q;
  logic [27:0] sync_q;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      meta_q <= SYNC_RST;
      sync_q <= SYNC_RST;
    end else begin
      meta_q <= {standby_pin, parallel_ctrl_wires, vs_below_uv, vs_above_op,
                 vdd_below_uv, vdd_in_lop, ol_on_det, ol_off_det, chan_fault,
                 chan_sense, spi_sclk, spi_csn, spi_mosi};
      sync_q <= meta_q;
    end
  end

  logic       stby_s, vs_uv_s, vs_op_s, vdd_uv_s, vdd_lop_s, open_load_on_flag_s, open_load_off_flag_s;
  logic       sclk_s, csn_s, mosi_s;
  logic [1:0] in_s;
  logic [7:0] fault_s, sense_s;
  assign {stby_s, in_s, vs_uv_s, vs_op_s, vdd_uv_s, vdd_lop_s, open_load_on_flag_s, open_load_off_flag_s,
          fault_s, sense_s, sclk_s, csn_s, mosi_s} = sync_q;

  // ---------------------------------------------------------------
  // operating mode
  // ---------------------------------------------------------------
  lhrsf_pkg::lhrsf_mode_t mode_q, mode_d;
  logic          limp, limp_prev_q, limp_rise, limp_fall;
  logic [7:0]    outen_q, map0_q, map1_q, err_q;
  logic          act_q, swrst_q, reg_rst, reg_rst_prev_q;
  logic [SW-1:0] settle_q;

  always_comb begin
    mode_d = lhrsf_pkg::M_IDLE;
    if (!stby_s && (|in_s))
      mode_d = lhrsf_pkg::M_LIMP;    // [RULE_01]
    else if (!stby_s)
      mode_d = lhrsf_pkg::M_SLEEP;
    else if ((|in_s) || (|outen_q) || act_q)
      mode_d = lhrsf_pkg::M_ACTIVE;  // [RULE_18]
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mode_q      <= lhrsf_pkg::M_SLEEP;
      limp_prev_q <= 1'b0;
    end else begin
      mode_q      <= mode_d;
      limp_prev_q <= limp;
    end
  end
  assign limp      = (mode_q == lhrsf_pkg::M_LIMP);
  assign limp_rise = limp && !limp_prev_q;
  assign limp_fall = !limp && limp_prev_q;

  // turn-on waits for the transition time when coming from sleep or idle
  always_ff @(posedge core_clk) begin
    if (!rst_n)
      settle_q <= SETTLE_LD;
    else if (mode_q != lhrsf_pkg::M_ACTIVE && !limp)
      settle_q <= SETTLE_LD;                 // [RULE_17]
    else if (settle_q != '0)
      settle_q <= settle_q - 1'b1;
  end

  // ---------------------------------------------------------------
  // serial frame engine
  // ---------------------------------------------------------------
  logic        sclk_d_q, csn_d_q;
  logic        sclk_rise, sclk_fall, csn_fall, csn_rise;
  logic [4:0]  bitcnt_q;
  logic [15:0] rx_q, tx_q, reply_w;
  logic        tx_diag_q, tx_ter_q;
  logic [2:0]  rsel_q;
  logic        frame_ok, frame_wr, frame_bad, diag_done;
  logic [2:0]  frame_addr;
  logic [7:0]  frame_data;
  logic        uv_q, lop_q, open_load_on_flag_q, open_load_off_flag_q, ter_q;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sclk_d_q <= 1'b0;
      csn_d_q  <= 1'b1;
    end else begin
      sclk_d_q <= sclk_s;
      csn_d_q  <= csn_s;
    end
  end
  assign sclk_rise = sclk_s && !sclk_d_q && !csn_s;
  assign sclk_fall = !sclk_s && sclk_d_q && !csn_s;
  assign csn_fall  = !csn_s && csn_d_q;
  assign csn_rise  = csn_s && !csn_d_q;

  function automatic logic [1:0] mode_code(input lhrsf_pkg::lhrsf_mode_t m);
    case (m)
      lhrsf_pkg::M_LIMP:   mode_code = lhrsf_pkg::MC_LIMP;   // [RULE_04]
      lhrsf_pkg::M_ACTIVE: mode_code = lhrsf_pkg::MC_ACTIVE;
      lhrsf_pkg::M_IDLE:   mode_code = lhrsf_pkg::MC_IDLE;
      default:             mode_code = lhrsf_pkg::MC_SLEEP;
    endcase
  endfunction

  // error and monitor bits stay readable in every mode
  function automatic logic [7:0] reg_read(input logic [2:0] a);
    case (a)
      lhrsf_pkg::SA_DIAG:  reg_read = err_q;      // [RULE_06]
      lhrsf_pkg::SA_OUTEN: reg_read = outen_q;
      lhrsf_pkg::SA_MAP0:  reg_read = map0_q;
      lhrsf_pkg::SA_MAP1:  reg_read = map1_q;
      lhrsf_pkg::SA_HWCR:  reg_read = {7'h00, act_q};
      lhrsf_pkg::SA_OSM:   reg_read = sense_s;    // [RULE_06]
      default:             reg_read = 8'h00;
    endcase
  endfunction

  always_comb reply_w = {ter_q, mode_code(mode_q), uv_q, lop_q, open_load_on_flag_q, open_load_off_flag_q, 1'b0,
                         reg_read(rsel_q)};

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      bitcnt_q  <= 5'h00;
      rx_q      <= 16'h0000;
      tx_q      <= 16'h0000;
      tx_diag_q <= 1'b0;
      tx_ter_q  <= 1'b0;
    end else if (csn_fall) begin
      bitcnt_q  <= 5'h00;
      tx_q      <= reply_w;
      tx_diag_q <= (rsel_q == lhrsf_pkg::SA_DIAG);
      tx_ter_q  <= ter_q;
    end else begin
      if (sclk_rise) begin
        rx_q <= {rx_q[14:0], mosi_s};
        if (bitcnt_q != 5'h1F)
          bitcnt_q <= bitcnt_q + 5'h01;
      end
      if (sclk_fall)
        tx_q <= {tx_q[14:0], 1'b0};
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      spi_miso    <= 1'b0;
      spi_miso_oe <= 1'b0;
    end else begin
      spi_miso_oe <= !csn_s;
      if (csn_fall)
        spi_miso <= reply_w[15];
      else if (sclk_fall)
        spi_miso <= tx_q[14];
    end
  end

  assign frame_ok   = csn_rise && (bitcnt_q == FRAME_CNT);
  assign frame_bad  = csn_rise && (bitcnt_q != FRAME_CNT) && (bitcnt_q != 5'h00);
  assign frame_addr = rx_q[lhrsf_pkg::CMD_ADDR_HI:lhrsf_pkg::CMD_ADDR_LO];
  assign frame_data = rx_q[7:0];
  // register writes are dropped in limp-home; the reply was already shifted out
  assign frame_wr   = frame_ok && rx_q[lhrsf_pkg::CMD_WR_BIT] && !limp;  // [RULE_02] [RULE_19]
  assign diag_done  = frame_ok && tx_diag_q;

  // a write frame points the next reply at standard diagnosis
  always_ff @(posedge core_clk) begin
    if (!rst_n)
      rsel_q <= lhrsf_pkg::SA_DIAG;
    else if (frame_ok)
      rsel_q <= rx_q[lhrsf_pkg::CMD_WR_BIT] ? lhrsf_pkg::SA_DIAG : frame_addr;
  end

  // ---------------------------------------------------------------
  // serial registers and their reset sources
  // ---------------------------------------------------------------
  assign reg_rst = vdd_uv_s || !stby_s || swrst_q;  // [RULE_10]

  always_ff @(posedge core_clk) begin
    if (!rst_n || reg_rst) begin
      outen_q <= lhrsf_pkg::OUTEN_RST;   // [RULE_07] [RULE_13]
      map0_q  <= lhrsf_pkg::MAP0_RST;
      map1_q  <= lhrsf_pkg::MAP1_RST;
      act_q   <= 1'b0;
    end else if (frame_wr) begin
      case (frame_addr)
        lhrsf_pkg::SA_OUTEN: outen_q <= frame_data;
        lhrsf_pkg::SA_MAP0:  map0_q  <= frame_data;
        lhrsf_pkg::SA_MAP1:  map1_q  <= frame_data;
        lhrsf_pkg::SA_HWCR:  act_q   <= frame_data[lhrsf_pkg::HWCR_ACT_BIT];
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n)
      swrst_q <= 1'b0;
    else
      swrst_q <= frame_wr && (frame_addr == lhrsf_pkg::SA_HWCR) &&
                 frame_data[lhrsf_pkg::SOFTWARE_RESET_BIT_BIT];
  end

  // error bits survive software reset and standby; only logic supply loss or a diagnosis write clears
  always_ff @(posedge core_clk) begin
    if (!rst_n || vdd_uv_s)
      err_q <= 8'h00;
    else if (frame_wr && frame_addr == lhrsf_pkg::SA_DIAG)
      err_q <= (err_q & ~frame_data) | fault_s;  // [RULE_11]
    else
      err_q <= err_q | fault_s;                  // [RULE_06]
  end

  // ---------------------------------------------------------------
  // status flags
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n)
      uv_q <= 1'b0;
    else if (limp || (vs_uv_s && mode_q != lhrsf_pkg::M_SLEEP))
      uv_q <= 1'b1;                             // [RULE_03] [RULE_14]
    else if (swrst_q || (diag_done && vs_op_s))
      uv_q <= 1'b0;                             // [RULE_12] [RULE_15]
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n)
      lop_q <= 1'b0;
    else if (limp || vdd_lop_s)
      lop_q <= 1'b1;                            // [RULE_03] [RULE_16]
    else if (swrst_q || diag_done)
      lop_q <= 1'b0;                            // [RULE_12] [RULE_16]
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n || limp) begin
      open_load_on_flag_q  <= 1'b0;                          // [RULE_03]
      open_load_off_flag_q <= 1'b0;
    end else begin
      open_load_on_flag_q  <= open_load_on_flag_s || (open_load_on_flag_q && !diag_done && !reg_rst);
      open_load_off_flag_q <= open_load_off_flag_s || (open_load_off_flag_q && !diag_done && !reg_rst);
    end
  end

  // raised at limp entry so the first reply carries it, then normal use
  always_ff @(posedge core_clk) begin
    if (!rst_n)
      ter_q <= 1'b0;
    else if (limp_rise || frame_bad)
      ter_q <= 1'b1;                            // [RULE_05]
    else if (frame_ok && tx_ter_q)
      ter_q <= 1'b0;
  end

  // ---------------------------------------------------------------
  // channel drive
  // ---------------------------------------------------------------
  logic [7:0] map_req, chan_d;
  assign map_req = ({8{in_s[0]}} & map0_q) | ({8{in_s[1]}} & map1_q);

  always_comb begin
    chan_d = 8'h00;
    if (settle_q == '0 && !vs_uv_s) begin
      if (limp)
        chan_d = map_req & lhrsf_pkg::LIMP_MASK & ~err_q;  // [RULE_08] [RULE_01]
      else if (mode_q == lhrsf_pkg::M_ACTIVE)
        chan_d = (outen_q | map_req) & ~err_q;             // [RULE_13]
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n)
      chan_on <= 8'h00;
    else
      chan_on <= chan_d;
  end

  // ---------------------------------------------------------------
  // local bus and interrupt
  // ---------------------------------------------------------------
  logic [lhrsf_pkg::EV_W-1:0] ev, irq_stat_q, irq_en_q, irq_clr;
  logic uv_prev_q, lop_prev_q;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      reg_rst_prev_q <= 1'b0;
      uv_prev_q      <= 1'b0;
      lop_prev_q     <= 1'b0;
    end else begin
      reg_rst_prev_q <= reg_rst;
      uv_prev_q      <= uv_q;
      lop_prev_q     <= lop_q;
    end
  end

  always_comb begin
    ev = '0;
    ev[lhrsf_pkg::EV_LIMP_IN]  = limp_rise;
    ev[lhrsf_pkg::EV_LIMP_OUT] = limp_fall;
    ev[lhrsf_pkg::EV_REG_RST]  = reg_rst && !reg_rst_prev_q;
    ev[lhrsf_pkg::EV_UV]       = uv_q && !uv_prev_q;
    ev[lhrsf_pkg::EV_LOP]      = lop_q && !lop_prev_q;
  end

  assign irq_clr = (bus_wr && bus_addr == lhrsf_pkg::BA_IRQ_CLR) ?
                   bus_wdata[lhrsf_pkg::EV_W-1:0] : '0;

  // an event in the clearing cycle stays set
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      irq_stat_q <= '0;
      irq_en_q   <= '0;
      irq        <= 1'b0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | ev;
      if (bus_wr && bus_addr == lhrsf_pkg::BA_IRQ_EN)
        irq_en_q <= bus_wdata[lhrsf_pkg::EV_W-1:0];
      irq <= |(((irq_stat_q & ~irq_clr) | ev) & irq_en_q);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n || !bus_rd)
      bus_rdata <= 32'h00000000;
    else begin
      case (bus_addr)
        lhrsf_pkg::BA_IRQ_STAT: bus_rdata <= {27'h0000000, irq_stat_q};
        lhrsf_pkg::BA_IRQ_EN:   bus_rdata <= {27'h0000000, irq_en_q};
        lhrsf_pkg::BA_STATUS:   bus_rdata <= {16'h0000, reply_w[15:9], 1'b0, chan_on};
        default:                bus_rdata <= 32'h00000000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  limp_entry_a: assert property (!stby_s && (|in_s) |=> limp)  // [RULE_01]
    else $error("limp-home not entered");
  limp_nowrite_a: assert property (limp && frame_ok |=> map0_q == lhrsf_pkg::MAP0_RST
                                   && outen_q == lhrsf_pkg::OUTEN_RST)  // [RULE_02]
    else $error("register changed in limp-home");
  limp_flags_a: assert property (limp && limp_prev_q |-> uv_q && lop_q
                                 && !open_load_on_flag_q && !open_load_off_flag_q)  // [RULE_03]
    else $error("limp-home flags not forced");
  limp_code_a: assert property (limp |-> reply_w[14:13] == lhrsf_pkg::MC_LIMP)  // [RULE_04]
    else $error("mode field wrong in limp-home");
  ter_first_a: assert property (limp_rise |=> ter_q [*2])  // [RULE_05]
    else $error("transmission error not raised");
  limp_chan_a: assert property (limp_prev_q |-> (chan_on & ~lhrsf_pkg::LIMP_MASK)
                                == 8'h00)  // [RULE_08]
    else $error("channel outside limp set is on");
  reg_reset_a: assert property (reg_rst |=> outen_q == lhrsf_pkg::OUTEN_RST
                                && map1_q == lhrsf_pkg::MAP1_RST && !act_q)  // [RULE_10]
    else $error("registers not reset");
  swrst_err_a: assert property (swrst_q && fault_s == 8'h00 && !vdd_uv_s
                                |=> err_q == $past(err_q))  // [RULE_11]
    else $error("error bits lost on software reset");
  swrst_flag_a: assert property (swrst_q && !limp && !vs_uv_s && !vdd_lop_s
                                 |=> !uv_q && !lop_q)  // [RULE_12]
    else $error("supply flags kept on software reset");
  uv_set_a: assert property (vs_uv_s && mode_q != lhrsf_pkg::M_SLEEP |=> uv_q)  // [RULE_14]
    else $error("undervoltage flag not set");
  uv_hold_a: assert property (uv_q && !diag_done && !swrst_q |=> uv_q)  // [RULE_15]
    else $error("undervoltage flag cleared early");
  lop_hold_a: assert property (lop_q && !diag_done && !swrst_q |=> lop_q)  // [RULE_16]
    else $error("low supply flag cleared early");
  settle_a: assert property (settle_q != '0 |=> chan_on == 8'h00)  // [RULE_17]
    else $error("channel on before transition time");
  active_a: assert property (stby_s && (|in_s) |=> mode_q == lhrsf_pkg::M_ACTIVE
                             ##1 settle_q != SETTLE_LD)  // [RULE_18]
    else $error("active mode not entered");

  limp_cov_c:   cover property (limp_rise ##[1:200] frame_ok);
  limp_wr_c:    cover property (limp && frame_ok && rx_q[lhrsf_pkg::CMD_WR_BIT]);
  diag_done_c:  cover property (uv_q ##1 diag_done ##1 !uv_q);
  swrst_c:      cover property (swrst_q && (|err_q));
endmodule
`default_nettype wire

// [lhrsf_pkg.sv]
// lhrsf_pkg: constants for the limp-home, register reset and supply flag block
// assumes one 125 MHz core clock; spi and supply comparators arrive asynchronously
// Overview of operation
// (RULE_01) standby low with a control wire high enters limp-home, driving mapped channel
// (RULE_02) in limp-home serial reads are answered, serial writes are ignored
// (RULE_03) limp-home entry forces both supply flags to one, both open-load flags to zero
// (RULE_04) limp-home reports operating mode field as binary 01
// (RULE_05) first reply after limp-home entry carries transmission error set, then normal
// (RULE_06) channel error and output status monitor bits keep working and stay readable
// (RULE_07) all other registers sit at default and refuse writes during limp-home
// (RULE_08) only channels 2 and 3 may be on in limp-home, supply permitting
// (RULE_09) controller avoids serial commands during active and limp-home changeover
// (RULE_10) registers default on logic supply loss, standby low, or software reset
// (RULE_11) software reset keeps channel error bits
// (RULE_12) software reset clears supply undervoltage and low logic supply flags
// (RULE_13) register reset drops channels not held by wires, restores input mapping
// (RULE_14) analog supply undervoltage while operating sets the undervoltage flag
// (RULE_15) undervoltage flag clears after recovery only at a standard diagnosis readout
// (RULE_16) low logic supply sets its flag; clears after recovery at diagnosis readout
// (RULE_17) channels turn on only after the mode transition time has elapsed; code skips the wait between active and limp-home
// (RULE_18) standby high with a wire high or an enable bit set enters active
// (RULE_19) serial write frames in limp-home are dropped, read reply still returned
`default_nettype none
package lhrsf_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_NS     = 8;
  localparam int TRANS_NS   = 200;
  localparam int TRANS_CYC  = (TRANS_NS + CLK_NS - 1) / CLK_NS;
  localparam int FRAME_BITS = 16;
  // ---------------------------------------------------------------
  // serial register map and defaults
  // ---------------------------------------------------------------
  localparam logic [2:0] SA_DIAG  = 3'h0;
  localparam logic [2:0] SA_OUTEN = 3'h1;
  localparam logic [2:0] SA_MAP0  = 3'h2;
  localparam logic [2:0] SA_MAP1  = 3'h3;
  localparam logic [2:0] SA_HWCR  = 3'h4;
  localparam logic [2:0] SA_OSM   = 3'h5;
  localparam int CMD_WR_BIT   = 15;
  localparam int CMD_ADDR_HI  = 14;
  localparam int CMD_ADDR_LO  = 12;
  localparam int HWCR_ACT_BIT = 0;
  localparam int SOFTWARE_RESET_BIT_BIT = 1;
  localparam logic [7:0] OUTEN_RST = 8'h00;
  localparam logic [7:0] MAP0_RST  = 8'h04;
  localparam logic [7:0] MAP1_RST  = 8'h08;
  localparam logic [7:0] LIMP_MASK = 8'h0C;
  localparam logic [1:0] MC_IDLE   = 2'h0;
  localparam logic [1:0] MC_LIMP   = 2'h1;
  localparam logic [1:0] MC_ACTIVE = 2'h2;
  localparam logic [1:0] MC_SLEEP  = 2'h3;
  typedef enum logic [1:0] {
    M_SLEEP  = 2'h0,
    M_IDLE   = 2'h1,
    M_ACTIVE = 2'h3,
    M_LIMP   = 2'h2
  } lhrsf_mode_t;
  // ---------------------------------------------------------------
  // local bus map
  // ---------------------------------------------------------------
  localparam logic [3:0] BA_IRQ_STAT = 4'h0;
  localparam logic [3:0] BA_IRQ_EN   = 4'h4;
  localparam logic [3:0] BA_IRQ_CLR  = 4'h8;
  localparam logic [3:0] BA_STATUS   = 4'hC;
  localparam int EV_W        = 5;
  localparam int EV_LIMP_IN  = 0;
  localparam int EV_LIMP_OUT = 1;
  localparam int EV_REG_RST  = 2;
  localparam int EV_UV       = 3;
  localparam int EV_LOP      = 4;
endpackage
`default_nettype wire

// [lhrsf_spi_master.sv]
// lhrsf_spi_master: behavioural spi mode 0 controller for the bench
// assumes core_clk at 125 MHz; sclk period is 10 core cycles (80 ns)
`timescale 1ns/100ps
`default_nettype none
module lhrsf_spi_master (
  input  wire logic core_clk,
  output logic      spi_sclk,
  output logic      spi_csn,
  output logic      spi_mosi,
  input  wire logic spi_miso
);
  initial begin
    spi_sclk = 1'b0;
    spi_csn  = 1'b1;
    spi_mosi = 1'b1;
  end
  // ---------------------------------------------------------------
  // one 16 bit frame, msb first
  // ---------------------------------------------------------------
  // sclk stands low between frames; mosi shows the inverse once released
  task automatic xfer(input logic [15:0] cmd, output logic [15:0] rsp);
    @(posedge core_clk);
    spi_csn  <= 1'b0;
    spi_mosi <= cmd[15];
    repeat (5) @(posedge core_clk);
    for (int i = 15; i >= 0; i--) begin
      spi_sclk <= 1'b1;
      rsp[i] = spi_miso;
      repeat (5) @(posedge core_clk);
      spi_sclk <= 1'b0;
      spi_mosi <= (i > 0) ? cmd[(i > 0) ? i - 1 : 0] : ~cmd[0];
      repeat (5) @(posedge core_clk);
    end
    spi_csn <= 1'b1;
    repeat (6) @(posedge core_clk);
  endtask
endmodule
`default_nettype wire

// [limp_home_reset_supply_flags_tb_top.sv]
// limp_home_reset_supply_flags_tb_top: self-checking bench for lhrsf_core
// assumes the serial controller model in lhrsf_spi_master
`timescale 1ns/100ps
`default_nettype none
module limp_home_reset_supply_flags_tb_top;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        standby_pin = 1'b0;
  logic [1:0]  parallel_ctrl_wires = 2'h0;
  logic        vs_below_uv = 1'b0;
  logic        vs_above_op = 1'b1;
  logic        vdd_below_uv = 1'b0;
  logic        vdd_in_lop = 1'b0;
  logic        ol_on_det = 1'b0;
  logic        ol_off_det = 1'b0;
  logic        spi_miso_oe;
  logic [7:0]  chan_fault = 8'h00;
  logic [7:0]  chan_sense = 8'h00;
  logic        spi_sclk, spi_csn, spi_mosi, spi_miso;
  logic [7:0]  chan_on;
  logic [3:0]  bus_addr = 4'h0;
  logic [31:0] bus_wdata = 32'h0;
  logic        bus_wr = 1'b0;
  logic        bus_rd = 1'b0;
  logic [31:0] bus_rdata, d;
  logic        irq;
  logic [15:0] r;
  int          fails = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  lhrsf_core i_lhrsf_core (.core_clk(core_clk), .rst_n(rst_n), .standby_pin(standby_pin),
    .parallel_ctrl_wires(parallel_ctrl_wires), .vs_below_uv(vs_below_uv),
    .vs_above_op(vs_above_op), .vdd_below_uv(vdd_below_uv), .vdd_in_lop(vdd_in_lop),
    .ol_on_det(ol_on_det), .ol_off_det(ol_off_det), .chan_fault(chan_fault),
    .chan_sense(chan_sense), .spi_sclk(spi_sclk), .spi_csn(spi_csn), .spi_mosi(spi_mosi),
    .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .chan_on(chan_on), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .irq(irq));
  lhrsf_spi_master i_lhrsf_spi_master (.core_clk(core_clk), .spi_sclk(spi_sclk),
    .spi_csn(spi_csn), .spi_mosi(spi_mosi), .spi_miso(spi_miso));

  always #4 core_clk = ~core_clk;

  task automatic finish_test();
    if (fails == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // 20k cycles is several times the length of the full sequence
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      finish_test();
    end
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] v);
    bus_addr  <= a;
    bus_wdata <= v;
    bus_wr    <= 1'b1;
    @(posedge core_clk);
    bus_wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] v);
    bus_addr <= a;
    bus_rd   <= 1'b1;
    @(posedge core_clk);
    bus_rd <= 1'b0;
    #1 v = bus_rdata;
    @(posedge core_clk);
  endtask
  task automatic frame(input logic [15:0] c);
    fork
      i_lhrsf_spi_master.xfer(c, r);
      begin
        tick(10);
        check("miso_oe_frame", 32'h1, 32'(spi_miso_oe));
      end
    join
    check("miso_oe_idle", 32'h0, 32'(spi_miso_oe));
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_active();
    standby_pin <= 1'b1;
    ol_on_det   <= 1'b1;
    ol_off_det  <= 1'b1;
    tick(10);
    frame(16'h9081);
    tick(5);
    check("turn_on_delay", 32'h0, 32'(chan_on));
    tick(40);
    check("chan_on_active", 32'h81, 32'(chan_on));
    reg_rd(lhrsf_pkg::BA_STATUS, d);
    check("mode_active", 32'(lhrsf_pkg::MC_ACTIVE), 32'(d[14:13]));
  endtask
  task automatic t_limp();
    reg_wr(lhrsf_pkg::BA_IRQ_EN, 32'h01);
    standby_pin         <= 1'b0;
    parallel_ctrl_wires <= 2'h1;
    chan_sense          <= 8'hA5;
    tick(40); // mode settles before any frame
    check("limp_chan", 32'h04, 32'(chan_on));
    check("irq_limp", 32'h1, 32'(irq));
    reg_rd(lhrsf_pkg::BA_STATUS, d);
    check("mode_limp", 32'(lhrsf_pkg::MC_LIMP), 32'(d[14:13]));
    check("limp_flags", 32'hC, 32'(d[12:9]));
    frame(16'h5000);
    check("ter_first", 32'h1, 32'(r[15]));
    frame(16'h90FF);
    check("ter_after", 32'h0, 32'(r[15]));
    check("osm_read", 32'hA5, 32'(r[7:0]));
    frame(16'h1000);
    frame(16'h1000);
    check("outen_default", 32'h0, 32'(r[7:0]));
    parallel_ctrl_wires <= 2'h3;
    tick(10);
    check("limp_two", 32'h0C, 32'(chan_on));
    reg_wr(lhrsf_pkg::BA_IRQ_CLR, 32'h1F);
    tick(2);
    check("irq_clear", 32'h0, 32'(irq));
  endtask
  task automatic t_soft_reset();
    standby_pin <= 1'b1;
    chan_fault  <= 8'h02;
    tick(40);
    chan_fault  <= 8'h00;
    parallel_ctrl_wires <= 2'h1;
    frame(16'hA040);
    frame(16'h9081);
    tick(40);
    check("mapped_on", 32'hC1, 32'(chan_on));
    // read frame first, so the reset frame's reply is no diagnosis readout
    frame(16'h5000);
    vs_below_uv <= 1'b1;
    vdd_in_lop  <= 1'b1;
    tick(10);
    vs_below_uv <= 1'b0;
    vdd_in_lop  <= 1'b0;
    tick(10);
    frame(16'hC002);
    tick(40);
    check("after_swrst", 32'h04, 32'(chan_on));
    reg_rd(lhrsf_pkg::BA_STATUS, d);
    check("flags_swrst", 32'h0, 32'(d[12:11]));
    reg_wr(lhrsf_pkg::BA_IRQ_CLR, 32'h1F);
    frame(16'h0000);
    check("err_kept", 32'h02, 32'(r[7:0]));
  endtask
  task automatic t_supply();
    reg_wr(lhrsf_pkg::BA_IRQ_EN, 32'h18);
    vs_below_uv <= 1'b1;
    vs_above_op <= 1'b0;
    vdd_in_lop  <= 1'b1;
    tick(10);
    reg_rd(lhrsf_pkg::BA_STATUS, d);
    check("flags_set", 32'h3, 32'(d[12:11]));
    check("irq_uv", 32'h1, 32'(irq));
    vs_below_uv <= 1'b0;
    vs_above_op <= 1'b1;
    vdd_in_lop  <= 1'b0;
    tick(10);
    reg_rd(lhrsf_pkg::BA_STATUS, d);
    check("flags_held", 32'h3, 32'(d[12:11]));
    frame(16'h0000);
    frame(16'h0000);
    reg_rd(lhrsf_pkg::BA_STATUS, d);
    check("flags_clr", 32'h0, 32'(d[12:11]));
    reg_wr(lhrsf_pkg::BA_IRQ_CLR, 32'h1F);
    reg_rd(4'h5, d);
    check("unmapped", 32'h0, d);
    check("irq_off", 32'h0, 32'(irq));
    frame(16'h9081);
    tick(40);
    vdd_below_uv <= 1'b1;
    tick(5);
    vdd_below_uv <= 1'b0;
    tick(40);
    check("vdd_reset", 32'h04, 32'(chan_on));
  endtask

  initial begin
    tick(8);
    rst_n <= 1'b1;
    tick(4);
    check("reset_chan", 32'h0, 32'(chan_on));
    t_active();
    t_limp();
    t_soft_reset();
    t_supply();
    finish_test();
  end
endmodule
`default_nettype wire
